// ### core/pic_level_enc.sv
// Lowest-number-wins encoder of active requests at one priority level.
module pic_level_enc
    import pic_pkg::*;
#(
    parameter int unsigned N = PIC_NUM_SRC
) (
    input wire logic [N-1:0] req,
    input wire logic [2*N-1:0] prio,
    input wire logic [1:0] level,
    input wire logic [N-1:0] fixed_mask,
    input wire logic [2*N-1:0] fixed_prio,
    output logic hit,
    output logic [$clog2(N)-1:0] idx
);
    // An encoder over fewer than two sources has no index to give.
    if (N < 2) begin : g_bad_n
        $error("pic_level_enc needs at least two sources");
    end
    always_comb begin
        hit = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i] && ((fixed_mask[i] ? fixed_prio[2*i +: 2] : prio[2*i +: 2]) == level)) begin
                hit = 1'b1;
                idx = i[$clog2(N)-1:0];
            end
        end
    end
endmodule : pic_level_enc

// ### core/pic_pkg.sv
// Package with register map, field layout and constants of the priority interrupt controller.
package pic_pkg;
    localparam int unsigned PIC_NUM_SRC = 64;
    localparam int unsigned PIC_ADDR_W = 5;
    localparam int unsigned PIC_DATA_W = 16;
    // Register indices (word addresses); priority fields occupy 8 words of 8 two-bit fields.
    localparam logic [4:0] PIC_REG_PRIO0 = 5'h00;
    localparam logic [4:0] PIC_REG_PRIO7 = 5'h07;
    localparam logic [4:0] PIC_REG_VBASE = 5'h08;
    localparam logic [4:0] PIC_REG_FM0 = 5'h09;
    localparam logic [4:0] PIC_REG_FAL0 = 5'h0a;
    localparam logic [4:0] PIC_REG_FAH0 = 5'h0b;
    localparam logic [4:0] PIC_REG_FM1 = 5'h0c;
    localparam logic [4:0] PIC_REG_FAL1 = 5'h0d;
    localparam logic [4:0] PIC_REG_FAH1 = 5'h0e;
    localparam logic [4:0] PIC_REG_PEND0 = 5'h0f;
    localparam logic [4:0] PIC_REG_PEND3 = 5'h12;
    localparam logic [4:0] PIC_REG_CTRL = 5'h16;
    // Field widths and positions.
    localparam int unsigned PIC_VNUM_W = 7;
    localparam int unsigned PIC_VBASE_W = 14;
    localparam int unsigned PIC_FAH_W = 5;
    localparam int unsigned PIC_VADDR_W = 21;
    localparam int unsigned PIC_CTRL_CODE_LSB = 0;
    localparam int unsigned PIC_CTRL_VALID_BIT = 2;
    // Vector number of source 0 in the vector table.
    localparam logic [6:0] PIC_VNUM_OFFSET = 7'h00;
    // Reset values.
    localparam logic [13:0] PIC_VBASE_RST = 14'h0000;
    localparam logic [20:0] PIC_BOOT_ADDR = 21'h000000;
    localparam logic [1:0] PIC_PRIO_RST = 2'h0;
    // Presented-level codes.
    localparam logic [1:0] PIC_CODE_NONE = 2'h0;
    localparam logic [1:0] PIC_CODE_L0 = 2'h1;
    localparam logic [1:0] PIC_CODE_L1 = 2'h2;
    localparam logic [1:0] PIC_CODE_L23 = 2'h3;
    localparam logic [1:0] PIC_FAST_LEVEL = 2'h2;
    typedef enum logic [1:0] {
        PIC_BOOT = 2'b01,
        PIC_RUN = 2'b10
    } pic_state_e;
endpackage : pic_pkg

// ### core/pic_top.sv
// Priority interrupt controller: register file, level arbitration, vector forming and wake-up.
// Behaviour
// - Each of the 64 request sources has a two-bit priority field choosing one of four levels, unless it is fixed.
// - Within a level the lowest-numbered active source wins, source 0 ranking highest.
// - A normal vector address is the vector base value followed by the winning vector number.
// - A two-bit code reports the presented level: 00 none, 01 level 0, 10 level 1, 11 level 2 or 3.
// - The winning vector number is compared with both fast-match registers and a match at level 2 is fast.
// - A fast interrupt supplies the address held in the matching fast-address low and high registers.
// - In wait and stop modes any pending enabled request is signalled to the system integration unit.
// - Only requests enabled before wait or stop was entered can wake the core.
// - After reset the controller drives the initial fetch address onto the core address bus.
// - The core is signalled only when an accepted-priority request is active, together with its address.
module pic_top
    import pic_pkg::*;
#(
    parameter int unsigned NUM_SRC = PIC_NUM_SRC,
    parameter logic [NUM_SRC-1:0] FIXED_MASK = '0,
    parameter logic [2*NUM_SRC-1:0] FIXED_PRIO = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [NUM_SRC-1:0] irq_in,
    input wire logic [1:0] core_mask,
    input wire logic low_power,
    input wire logic boot_ack,
    input wire logic [PIC_ADDR_W-1:0] reg_addr,
    input wire logic [PIC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [PIC_DATA_W-1:0] reg_rdata,
    output logic irq_to_core,
    output logic fast_irq,
    output logic [PIC_VADDR_W-1:0] vector_addr,
    output logic [1:0] presented_priority_code,
    output logic boot_addr_valid,
    output logic wake_req
);
    localparam int unsigned IW = $clog2(NUM_SRC);

    // The register map and vector numbers are laid out for exactly 64 sources.
    if (NUM_SRC != 64) begin : g_bad_num_src
        $error("pic_top supports exactly 64 sources");
    end

    // Request pins come from other logic; two stages keep them clean anyway.
    logic [NUM_SRC-1:0] sync1_q, sync2_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= irq_in;
            sync2_q <= sync1_q;
        end
    end

    // Register state.
    logic [2*NUM_SRC-1:0] prio_q, prio_d;
    logic [PIC_VBASE_W-1:0] vbase_q, vbase_d;
    logic [PIC_VNUM_W-1:0] fm0_q, fm0_d, fm1_q, fm1_d;
    logic [PIC_DATA_W-1:0] fal0_q, fal0_d, fal1_q, fal1_d;
    logic [PIC_FAH_W-1:0] fah0_q, fah0_d, fah1_q, fah1_d;
    logic [NUM_SRC-1:0] wake_en_q, wake_en_d;
    logic lp_q;
    logic [PIC_DATA_W-1:0] rdata_d;

    always_comb begin
        prio_d = prio_q;
        vbase_d = vbase_q;
        fm0_d = fm0_q;
        fm1_d = fm1_q;
        fal0_d = fal0_q;
        fal1_d = fal1_q;
        fah0_d = fah0_q;
        fah1_d = fah1_q;
        rdata_d = '0;
        if (reg_wr) begin
            if (reg_addr <= PIC_REG_PRIO7) begin
                prio_d[reg_addr[2:0]*16 +: 16] = reg_wdata;
            end
            unique case (reg_addr)
                PIC_REG_VBASE: vbase_d = reg_wdata[PIC_VBASE_W-1:0];
                PIC_REG_FM0: fm0_d = reg_wdata[PIC_VNUM_W-1:0];
                PIC_REG_FAL0: fal0_d = reg_wdata;
                PIC_REG_FAH0: fah0_d = reg_wdata[PIC_FAH_W-1:0];
                PIC_REG_FM1: fm1_d = reg_wdata[PIC_VNUM_W-1:0];
                PIC_REG_FAL1: fal1_d = reg_wdata;
                PIC_REG_FAH1: fah1_d = reg_wdata[PIC_FAH_W-1:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            if (reg_addr <= PIC_REG_PRIO7) begin
                rdata_d = prio_q[reg_addr[2:0]*16 +: 16];
            end else if (reg_addr >= PIC_REG_PEND0 && reg_addr <= PIC_REG_PEND3) begin
                rdata_d = sync2_q[(reg_addr - PIC_REG_PEND0)*16 +: 16];
            end else begin
                unique case (reg_addr)
                    PIC_REG_VBASE: rdata_d = {2'h0, vbase_q};
                    PIC_REG_FM0: rdata_d = {9'h000, fm0_q};
                    PIC_REG_FAL0: rdata_d = fal0_q;
                    PIC_REG_FAH0: rdata_d = {11'h000, fah0_q};
                    PIC_REG_FM1: rdata_d = {9'h000, fm1_q};
                    PIC_REG_FAL1: rdata_d = fal1_q;
                    PIC_REG_FAH1: rdata_d = {11'h000, fah1_q};
                    PIC_REG_CTRL: rdata_d = {13'h0000, irq_to_core, presented_priority_code};
                    default: rdata_d = '0;
                endcase
            end
        end
    end

    // enable set frozen at entry
    // Freezing on the raw mode input keeps the mask that was in force before entry.
    always_comb begin
        wake_en_d = wake_en_q;
        if (!low_power) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                wake_en_d[i] = (FIXED_MASK[i] ? FIXED_PRIO[2*i +: 2] : prio_q[2*i +: 2]) >= core_mask;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prio_q <= {NUM_SRC{PIC_PRIO_RST}};
            vbase_q <= PIC_VBASE_RST;
            fm0_q <= '0;
            fm1_q <= '0;
            fal0_q <= '0;
            fal1_q <= '0;
            fah0_q <= '0;
            fah1_q <= '0;
            wake_en_q <= '0;
            lp_q <= 1'b0;
            reg_rdata <= '0;
        end else begin
            prio_q <= prio_d;
            vbase_q <= vbase_d;
            fm0_q <= fm0_d;
            fm1_q <= fm1_d;
            fal0_q <= fal0_d;
            fal1_q <= fal1_d;
            fah0_q <= fah0_d;
            fah1_q <= fah1_d;
            wake_en_q <= wake_en_d;
            lp_q <= low_power;
            reg_rdata <= rdata_d;
        end
    end

    // One encoder per level.
    logic [3:0] lvl_hit;
    logic [IW-1:0] lvl_idx [4];
    for (genvar l = 0; l < 4; l++) begin : g_lvl
        pic_level_enc #(.N(NUM_SRC)) u_enc (
            .req(sync2_q),
            .prio(prio_q),
            .level(2'(l)),
            .fixed_mask(FIXED_MASK),
            .fixed_prio(FIXED_PRIO),
            .hit(lvl_hit[l]),
            .idx(lvl_idx[l])
        );
    end

    // Arbitration and vector forming.
    pic_state_e state_q, state_d;
    logic irq_d, fast_d, wake_d;
    logic [PIC_VADDR_W-1:0] vaddr_d;
    logic [1:0] code_d, win_lvl;
    logic win_hit;
    logic [PIC_VNUM_W-1:0] win_vnum;

    always_comb begin
        win_hit = 1'b0;
        win_lvl = 2'h0;
        for (int l = 0; l < 4; l++) begin
            if (lvl_hit[l] && (l[1:0] >= core_mask)) begin
                win_hit = 1'b1;
                win_lvl = l[1:0];
            end
        end
        win_vnum = PIC_VNUM_OFFSET + {1'b0, lvl_idx[win_lvl]};
        state_d = state_q;
        irq_d = 1'b0;
        fast_d = 1'b0;
        code_d = PIC_CODE_NONE;
        vaddr_d = '0;
        wake_d = lp_q && |(sync2_q & wake_en_q);
        unique case (state_q)
            PIC_BOOT: begin
                vaddr_d = PIC_BOOT_ADDR;
                if (boot_ack) begin
                    state_d = PIC_RUN;
                end
            end
            PIC_RUN: begin
                if (win_hit) begin
                    irq_d = 1'b1;
                    unique case (win_lvl)
                        2'h0: code_d = PIC_CODE_L0;
                        2'h1: code_d = PIC_CODE_L1;
                        default: code_d = PIC_CODE_L23;
                    endcase
                    if (win_lvl == PIC_FAST_LEVEL && win_vnum == fm0_q) begin
                        fast_d = 1'b1;
                        vaddr_d = {fah0_q, fal0_q};
                    end else if (win_lvl == PIC_FAST_LEVEL && win_vnum == fm1_q) begin
                        fast_d = 1'b1;
                        vaddr_d = {fah1_q, fal1_q};
                    end else begin
                        vaddr_d = {vbase_q, win_vnum};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= PIC_BOOT;
            irq_to_core <= 1'b0;
            fast_irq <= 1'b0;
            vector_addr <= PIC_BOOT_ADDR;
            presented_priority_code <= PIC_CODE_NONE;
            boot_addr_valid <= 1'b1;
            wake_req <= 1'b0;
        end else begin
            state_q <= state_d;
            irq_to_core <= irq_d;
            fast_irq <= fast_d;
            vector_addr <= vaddr_d;
            presented_priority_code <= code_d;
            boot_addr_valid <= (state_d == PIC_BOOT);
            wake_req <= wake_d;
        end
    end
endmodule : pic_top

// ### tb/pic_core_model.sv
// Behavioural core and system unit facing the interrupt controller.
module pic_core_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic boot_addr_valid,
    input wire logic [1:0] mask_cmd,
    input wire logic sleep_cmd,
    output logic [1:0] core_mask,
    output logic low_power,
    output logic boot_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            core_mask <= 2'h0;
            low_power <= 1'b0;
            boot_ack <= 1'b0;
        end else begin
            core_mask <= mask_cmd;
            low_power <= sleep_cmd;
            boot_ack <= boot_addr_valid && !boot_ack;
        end
    end
endmodule : pic_core_model

// ### tb/pic_top_monitor.sv
// Concurrent checks on the ports of the priority interrupt controller.
module pic_top_monitor
    import pic_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [1:0] core_mask,
    input wire logic low_power,
    input wire logic boot_ack,
    input wire logic irq_to_core,
    input wire logic fast_irq,
    input wire logic [20:0] vector_addr,
    input wire logic [1:0] presented_priority_code,
    input wire logic boot_addr_valid,
    input wire logic wake_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_code; irq_to_core |-> presented_priority_code != PIC_CODE_NONE; endproperty
    a_code: assert property (p_code) else $error("request shown with idle code");
    property p_boot; boot_addr_valid |-> !irq_to_core && vector_addr == PIC_BOOT_ADDR; endproperty
    a_boot: assert property (p_boot) else $error("boot phase output wrong");
    property p_mask; irq_to_core && $stable(core_mask) |->
        presented_priority_code > core_mask || presented_priority_code == PIC_CODE_L23; endproperty
    a_mask: assert property (p_mask) else $error("masked level presented");
    property p_fast; fast_irq |-> irq_to_core && presented_priority_code == PIC_CODE_L23; endproperty
    a_fast: assert property (p_fast) else $error("fast flag without level 2");
    property p_idle; !irq_to_core && !boot_addr_valid |->
        vector_addr == '0 && !fast_irq && presented_priority_code == PIC_CODE_NONE; endproperty
    a_idle: assert property (p_idle) else $error("outputs active without request");
    property p_wake; wake_req |-> $past(low_power, 2); endproperty
    a_wake: assert property (p_wake) else $error("wake outside low power");
    property p_boot_end; boot_addr_valid && boot_ack |-> ##[1:2] !boot_addr_valid; endproperty
    a_boot_end: assert property (p_boot_end) else $error("boot phase did not end");
    property p_boot_once; !boot_addr_valid |=> !boot_addr_valid; endproperty
    a_boot_once: assert property (p_boot_once) else $error("boot phase came back");
endmodule : pic_top_monitor
bind pic_top pic_top_monitor pic_top_monitor_inst (.clk(clk), .nrst(nrst), .core_mask(core_mask),
    .low_power(low_power), .boot_ack(boot_ack), .irq_to_core(irq_to_core), .fast_irq(fast_irq),
    .vector_addr(vector_addr), .presented_priority_code(presented_priority_code),
    .boot_addr_valid(boot_addr_valid), .wake_req(wake_req));

// ### tb/pic_top_tb.sv
// Self-checking bench of the priority interrupt controller.
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module pic_top_tb import pic_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sleep_cmd = 1'b0, probe = 1'b0;
    logic rd_q = 1'b0, probe_q = 1'b0, low_power, boot_ack, irq_to_core, fast_irq, boot_addr_valid, wake_req;
    logic [63:0] irq_in = '0;
    logic [4:0] reg_addr = '0;
    logic [15:0] reg_wdata = '0, d, reg_rdata, rv[15];
    logic [1:0] mask_cmd = '0, core_mask, presented_priority_code, m;
    logic [20:0] vector_addr;
    logic [31:0] lfsr = 32'hb7b4b0e5, x, expq[$];
    logic [26:0] e, f;
    int n_errors = 0, num_checks = 0, cycles = 0;
    pic_top pic_top_inst (.clk(clk), .nrst(nrst), .irq_in(irq_in), .core_mask(core_mask), .low_power(low_power),
        .boot_ack(boot_ack), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq_to_core(irq_to_core), .fast_irq(fast_irq), .vector_addr(vector_addr),
        .presented_priority_code(presented_priority_code), .boot_addr_valid(boot_addr_valid), .wake_req(wake_req));
    pic_core_model pic_core_model_inst (.clk(clk), .nrst(nrst), .boot_addr_valid(boot_addr_valid),
        .mask_cmd(mask_cmd), .sleep_cmd(sleep_cmd), .core_mask(core_mask), .low_power(low_power), .boot_ack(boot_ack));
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
        return lfsr;
    endfunction : rnd
    function automatic logic [15:0] msk(input int a);
        case (a)
            8: return 16'h3fff;
            9, 12: return 16'h007f;
            11, 14: return 16'h001f;
            default: return (a < 14) ? 16'hffff : 16'h0000;
        endcase
    endfunction : msk
    function automatic logic [26:0] exp_out(input logic [1:0] mk, input logic lp);
        int w;
        int lv;
        logic [6:0] vn;
        logic fst;
        w = -1;
        lv = 0;
        for (int l = 3; l >= int'(mk); l--)
            for (int i = 0; i < 64; i++)
                if (w < 0 && irq_in[i] && rv[i / 8][2 * (i % 8) +: 2] == 2'(l)) begin
                    w = i;
                    lv = l;
                end
        if (w < 0)
            return '0;
        vn = 7'(w) + PIC_VNUM_OFFSET;
        fst = lv == 2 && (vn == rv[9][6:0] || vn == rv[12][6:0]);
        return {1'b0, lp, 1'b1, fst, 2'((lv > 1) ? 3 : lv + 1), fst ? ((vn == rv[9][6:0]) ?
            {rv[11][4:0], rv[10]} : {rv[14][4:0], rv[13]}) : {rv[8][13:0], vn}};
    endfunction : exp_out
    task automatic wr(input int a, input logic [15:0] dv);
        reg_addr <= 5'(a);
        reg_wdata <= dv;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input int a, input logic [31:0] xv);
        expq.push_back(xv);
        reg_addr <= 5'(a);
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : rd
    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : idle
    task automatic look(input logic [26:0] xv);
        expq.push_back(32'(xv));
        probe <= 1'b1;
        @(posedge clk);
        probe <= 1'b0;
    endtask : look
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    initial begin
        forever #5 clk = ~clk;
    end
    // Outputs are compared mid-cycle so registered values have settled.
    always @(posedge clk) begin
        rd_q <= reg_rd;
        probe_q <= probe;
        cycles <= cycles + 1;
        if (cycles > 10000) begin
            n_errors++;
            end_of_test();
        end
    end
    always @(negedge clk) begin
        if (rd_q || probe_q)
            x = expq.pop_front();
        if (rd_q)
            `CHK(reg_rdata, x[15:0])
        if (probe_q)
            `CHK({boot_addr_valid, wake_req, irq_to_core, fast_irq, presented_priority_code, vector_addr}, x[26:0])
    end
    initial begin
        @(posedge clk);
        look({1'b1, 5'h0, PIC_BOOT_ADDR});
        nrst <= 1'b1;
        idle(4);
        for (int a = 0; a < 9; a++)
            rd(a, (a < 8) ? 32'({8{PIC_PRIO_RST}}) : 32'(PIC_VBASE_RST));
        for (int a = 0; a < 32; a++)
            if (!(a inside {[15:18], 22})) begin
                d = 16'(rnd());
                wr(a, d);
                rd(a, 32'(d & msk(a)));
            end
        for (int t = 0; t < 150; t++) begin
            for (int a = 0; a < 15; a++) begin
                rv[a] = 16'(rnd()) & msk(a) & ((a == 9 || a == 12) ? 16'h0007 : 16'hffff);
                wr(a, rv[a]);
            end
            m = 2'(rnd());
            mask_cmd <= m;
            irq_in <= (t % 8 == 0) ? '0 : {rnd(), rnd()} & {rnd(), rnd()} & {rnd(), rnd()};
            idle(5);
            e = exp_out(m, 1'b0);
            look(e);
            for (int a = 15; a < 19; a++)
                rd(a, 32'(irq_in[(a - 15) * 16 +: 16]));
            rd(22, 32'({e[24], e[22:21]}));
            sleep_cmd <= 1'b1;
            mask_cmd <= 2'h3;
            idle(3);
            f = exp_out(2'h3, 1'b0);
            e = exp_out(m, 1'b1);
            look({1'b0, e[25], f[24:0]});
            sleep_cmd <= 1'b0;
            idle(2);
        end
        idle(3);
        end_of_test();
    end
endmodule : pic_top_tb
